// ---- pulse_origin_pkg.sv ----
/*
  Shared constants and types for the pulse output and origin search channel:
  register offsets, control and status layouts, search states and timing counts.
  Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package pulse_origin_pkg;

  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PERIOD = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_POS = 4'hc;

  // control word, bit 0 upward: pulse_dir_mode, origin_mode[2:1], run, dir_cw, search_cw, cw_limit, ccw_limit
  typedef struct packed {
    logic ccw_limit;      // copied in by the program each scan
    logic cw_limit;       // copied in by the program each scan
    logic search_cw;      // origin search travel direction, 1 = clockwise
    logic dir_cw;         // manual travel direction, 1 = clockwise
    logic run;            // manual pulse output enable
    logic [1:0] origin_mode;
    logic pulse_dir_mode; // 0 = cw/ccw lines, 1 = step plus direction
  } ctrl_t;
  localparam int CTRL_W = 8;
  localparam ctrl_t CTRL_RESET = ctrl_t'(8'h00);
  localparam int START_BIT = 8; // write-one pulse, reads zero

  // half period of the step train in clock cycles
  localparam int PERIOD_W = 16;
  localparam logic [15:0] PERIOD_RESET = 16'h0064;

  // status word, bit 5 downward
  typedef struct packed {
    logic fault;
    logic done;
    logic settling;
    logic clearing;
    logic seeking;
    logic moving;
  } status_t;
  localparam int STATUS_W = 6;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SEEK = 3'b001,
    S_CLEAR = 3'b010,
    S_SETTLE = 3'b011,
    S_DONE = 3'b100,
    S_FAULT = 3'b101
  } search_state_t;

  // origin search operation modes
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_CLEAR = 2'h1;
  localparam logic [1:0] MODE_SETTLE = 2'h2;

  // error clear pulse width, least time rounded up
  localparam int CLK_PERIOD_NS = 4;
  localparam int ERR_CLEAR_NS = 2000;
  localparam int ERR_CLEAR_CYC = (ERR_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLR_CNT_W = 10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pulse_origin_pkg

// ---- pulse_origin_io.sv ----
/*
  One pulse output channel with origin search, behind an AXI4-Lite slave.
  Assumes all line inputs are already synchronous to aclk and that the program
  copies the limit sensors into the control word every scan.
*/
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
// Functional notes
// R1: in cw/ccw mode clockwise pulses go out on the cw line and counter-clockwise pulses on the ccw line.
// R2: in step plus direction mode the step train goes on the step line and the direction level on the other.
// R3: a pulse output stays off whenever no pulses are being produced.
// R4: the direction line off means counter-clockwise and on means clockwise.
// R5: the program samples the cw and ccw limit sensors and copies them into the limit bits every scan.
// R6: in mode 0 the origin is fixed at the rising edge of the origin input.
// R7: in mode 0 the error clear output stays unused and the positioning done input is ignored.
// R8: in mode 1 the error clear output turns on when the origin is fixed at an origin rising edge.
// R9: mode 2 works as mode 1 and also waits on the drive's positioning done input to finish the search.
// R10: in mode 2 the search does not finish before positioning done is seen from the drive.
// R11: in mode 2 the drive holds positioning done off while moving and on once stopped.
`timescale 1ns/1ps
module pulse_origin_io (
  input wire logic aclk,                   // 250 MHz system clock
  input wire logic aresetn,                // synchronous reset, active low
  input wire logic ce,                     // clock enable, freezes all state when low
  input wire logic [3:0] s_axi_awaddr,     // write address
  input wire logic s_axi_awvalid,          // write address valid
  output logic s_axi_awready,              // write address ready
  input wire logic [31:0] s_axi_wdata,     // write data
  input wire logic [3:0] s_axi_wstrb,      // write byte strobes
  input wire logic s_axi_wvalid,           // write data valid
  output logic s_axi_wready,               // write data ready
  output logic [1:0] s_axi_bresp,          // write response
  output logic s_axi_bvalid,               // write response valid
  input wire logic s_axi_bready,           // write response ready
  input wire logic [3:0] s_axi_araddr,     // read address
  input wire logic s_axi_arvalid,          // read address valid
  output logic s_axi_arready,              // read address ready
  output logic [31:0] s_axi_rdata,         // read data
  output logic [1:0] s_axi_rresp,          // read response
  output logic s_axi_rvalid,               // read data valid
  input wire logic s_axi_rready,           // read data ready
  input wire logic origin_in_line,         // origin sensor or phase-z
  input wire logic origin_proximity_line,  // origin proximity sensor
  input wire logic positioning_done_line,  // drive positioning completed
  output logic step_pulse_line,            // step train, step plus direction mode
  output logic cw_pulse_line,              // clockwise pulses, cw/ccw mode
  output logic ccw_or_direction_line,      // ccw pulses or direction level
  output logic error_clear_line            // drive error counter reset
);

  pulse_origin_pkg::ctrl_t ctrl_q;
  logic [15:0] period_q;
  logic start_q;
  pulse_origin_pkg::search_state_t state_q;
  logic [9:0] clr_cnt_q;
  logic err_q;
  logic origin_prev_q;
  logic prox_seen_q;
  logic [15:0] div_q;
  logic phase_q;
  logic [31:0] pos_q;
  logic step_q, cw_q, ccw_dir_q;
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic seeking, manual_ok, dir_act, blocked, moving, half_hit, step_rise, origin_rise, fix, write_fire;
  pulse_origin_pkg::status_t status;

  // bus handshakes; nothing is taken while the clock enable is low
  assign s_axi_awready = ce && !aw_have_q && !bvalid_q;
  assign s_axi_wready = ce && !w_have_q && !bvalid_q;
  assign s_axi_arready = ce && !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign write_fire = aw_have_q && w_have_q && !bvalid_q;

  // line outputs come straight from flops
  assign step_pulse_line = step_q;
  assign cw_pulse_line = cw_q;
  assign ccw_or_direction_line = ccw_dir_q;
  assign error_clear_line = err_q;

  // motion decision: search travel overrides manual run, limits stop travel into them
  always_comb begin
    seeking = (state_q == pulse_origin_pkg::S_SEEK);
    manual_ok = (state_q == pulse_origin_pkg::S_IDLE) || (state_q == pulse_origin_pkg::S_DONE) ||
                (state_q == pulse_origin_pkg::S_FAULT);
    dir_act = seeking ? ctrl_q.search_cw : ctrl_q.dir_cw;
    blocked = dir_act ? ctrl_q.cw_limit : ctrl_q.ccw_limit; // see R5
    moving = (seeking || (manual_ok && ctrl_q.run)) && !blocked;
    half_hit = ({1'b0, div_q} + 17'h00001) >= {1'b0, period_q};
    step_rise = moving && half_hit && !phase_q;
    origin_rise = origin_in_line && !origin_prev_q;
    fix = seeking && prox_seen_q && origin_rise && !blocked;
    status = '{fault: state_q == pulse_origin_pkg::S_FAULT, done: state_q == pulse_origin_pkg::S_DONE,
               settling: state_q == pulse_origin_pkg::S_SETTLE, clearing: err_q, seeking: seeking,
               moving: moving};
  end

  // write address and data are caught independently, then applied together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= pulse_origin_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (write_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        case (aw_addr_q)
          pulse_origin_pkg::ADDR_CTRL, pulse_origin_pkg::ADDR_PERIOD,
          pulse_origin_pkg::ADDR_STATUS, pulse_origin_pkg::ADDR_POS: bresp_q <= pulse_origin_pkg::RESP_OKAY;
          default: bresp_q <= pulse_origin_pkg::RESP_SLVERR;
        endcase
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // software registers; start is a one-cycle pulse from a write of one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= pulse_origin_pkg::CTRL_RESET;
      period_q <= pulse_origin_pkg::PERIOD_RESET;
      start_q <= 1'b0;
    end else if (ce) begin
      start_q <= 1'b0;
      if (write_fire && aw_addr_q == pulse_origin_pkg::ADDR_CTRL) begin
        if (w_strb_q[0]) begin
          ctrl_q <= pulse_origin_pkg::ctrl_t'(w_data_q[pulse_origin_pkg::CTRL_W-1:0]);
        end
        start_q <= w_strb_q[1] && w_data_q[pulse_origin_pkg::START_BIT];
      end
      if (write_fire && aw_addr_q == pulse_origin_pkg::ADDR_PERIOD) begin
        if (w_strb_q[0]) begin
          period_q[7:0] <= w_data_q[7:0];
        end
        if (w_strb_q[1]) begin
          period_q[15:8] <= w_data_q[15:8];
        end
      end
    end
  end

  // read port, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= pulse_origin_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rresp_q <= pulse_origin_pkg::RESP_OKAY;
        case (s_axi_araddr)
          pulse_origin_pkg::ADDR_CTRL: rdata_q <= {24'h000000, ctrl_q};
          pulse_origin_pkg::ADDR_PERIOD: rdata_q <= {16'h0000, period_q};
          pulse_origin_pkg::ADDR_STATUS: rdata_q <= {26'h0000000, status};
          pulse_origin_pkg::ADDR_POS: rdata_q <= pos_q;
          default: begin
            rdata_q <= 32'h00000000;
            rresp_q <= pulse_origin_pkg::RESP_SLVERR;
          end
        endcase
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // step generator: half-period divider, phase forced low when idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 16'h0000;
      phase_q <= 1'b0;
    end else if (ce) begin
      if (!moving) begin
        div_q <= 16'h0000;
        phase_q <= 1'b0; // see R3
      end else if (half_hit) begin
        div_q <= 16'h0000;
        phase_q <= !phase_q;
      end else begin
        div_q <= div_q + 16'h0001;
      end
    end
  end

  // output routing by pulse mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_q <= 1'b0;
      cw_q <= 1'b0;
      ccw_dir_q <= 1'b0;
    end else if (ce) begin
      step_q <= ctrl_q.pulse_dir_mode && moving && phase_q; // see R2
      cw_q <= !ctrl_q.pulse_dir_mode && moving && phase_q && dir_act; // see R1
      if (ctrl_q.pulse_dir_mode) begin
        ccw_dir_q <= dir_act; // see R4
      end else begin
        ccw_dir_q <= moving && phase_q && !dir_act; // see R1
      end
    end
  end

  // present position, zeroed where the origin is fixed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_q <= 32'h00000000;
    end else if (ce) begin
      if (fix) begin
        pos_q <= 32'h00000000; // see R6
      end else if (step_rise) begin
        pos_q <= dir_act ? pos_q + 32'h00000001 : pos_q - 32'h00000001;
      end
    end
  end

  // origin edge and proximity tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      origin_prev_q <= 1'b0;
      prox_seen_q <= 1'b0;
    end else if (ce) begin
      origin_prev_q <= origin_in_line;
      if (start_q) begin
        prox_seen_q <= 1'b0;
      end else if (seeking && origin_proximity_line) begin
        prox_seen_q <= 1'b1;
      end
    end
  end

  // origin search sequence and error clear pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= pulse_origin_pkg::S_IDLE;
      clr_cnt_q <= 10'h000;
      err_q <= 1'b0;
    end else if (ce) begin
      case (state_q)
        pulse_origin_pkg::S_IDLE, pulse_origin_pkg::S_DONE, pulse_origin_pkg::S_FAULT: begin
          if (start_q) begin
            state_q <= pulse_origin_pkg::S_SEEK;
          end
        end
        pulse_origin_pkg::S_SEEK: begin
          if (blocked) begin
            state_q <= pulse_origin_pkg::S_FAULT;
          end else if (fix && ctrl_q.origin_mode == pulse_origin_pkg::MODE_PLAIN) begin
            state_q <= pulse_origin_pkg::S_DONE; // see R7
          end else if (fix) begin
            state_q <= pulse_origin_pkg::S_CLEAR;
            clr_cnt_q <= 10'h000;
            err_q <= 1'b1; // see R8
          end
        end
        pulse_origin_pkg::S_CLEAR: begin
          if (clr_cnt_q == 10'(pulse_origin_pkg::ERR_CLEAR_CYC - 1)) begin
            err_q <= 1'b0;
            if (ctrl_q.origin_mode == pulse_origin_pkg::MODE_SETTLE) begin
              state_q <= pulse_origin_pkg::S_SETTLE; // see R9
            end else begin
              state_q <= pulse_origin_pkg::S_DONE;
            end
          end else begin
            clr_cnt_q <= clr_cnt_q + 10'h001;
          end
        end
        pulse_origin_pkg::S_SETTLE: begin
          if (positioning_done_line) begin
            state_q <= pulse_origin_pkg::S_DONE; // see R10
          end
        end
        default: state_q <= pulse_origin_pkg::S_IDLE;
      endcase
    end
  end

  // checks, all but settle_hold_a assuming ce high around the checked window
  localparam int CLR_A = pulse_origin_pkg::ERR_CLEAR_CYC;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  cw_ccw_route_a: assert property (ce && !ctrl_q.pulse_dir_mode && moving && phase_q |=> // see R1
    (cw_pulse_line == $past(dir_act)) && (ccw_or_direction_line == !$past(dir_act)) && !step_pulse_line)
    else $error("cw/ccw pulse routed to wrong line");
  step_dir_route_a: assert property (ce && ctrl_q.pulse_dir_mode |=> // see R2
    !cw_pulse_line && (step_pulse_line == $past(moving && phase_q)))
    else $error("step train misrouted in step plus direction mode");
  idle_off_a: assert property (ce && !moving |=> !step_pulse_line && !cw_pulse_line) // see R3
    else $error("pulse output on while idle");
  dir_level_a: assert property (ce && ctrl_q.pulse_dir_mode |=> ccw_or_direction_line == $past(dir_act)) // see R4
    else $error("direction level does not match travel");
  origin_fix_a: assert property (ce && fix |=> pos_q == 32'h00000000 && !seeking) // see R6
    else $error("origin not fixed at origin rising edge");
  mode0_no_clear_a: assert property (ce && fix && ctrl_q.origin_mode == pulse_origin_pkg::MODE_PLAIN |=> // see R7
    status.done && !error_clear_line)
    else $error("mode 0 used error clear or waited");
  clear_on_fix_a: assert property (ce && fix && ctrl_q.origin_mode != pulse_origin_pkg::MODE_PLAIN |=> // see R8
    error_clear_line [*8])
    else $error("error clear not driven at origin fix");
  clear_ends_a: assert property (ce && $rose(error_clear_line) |-> ##[1:CLR_A] !error_clear_line) // see R8
    else $error("error clear pulse too long");
  settle_exit_a: assert property (ce && state_q == pulse_origin_pkg::S_SETTLE && positioning_done_line |=> // see R9
    status.done)
    else $error("search did not finish on positioning done");
  settle_hold_a: assert property (state_q == pulse_origin_pkg::S_SETTLE && !positioning_done_line |=> // see R10
    !status.done)
    else $error("search finished before positioning done");

  mode0_done_c: cover property (fix && ctrl_q.origin_mode == pulse_origin_pkg::MODE_PLAIN);
  mode2_done_c: cover property (state_q == pulse_origin_pkg::S_SETTLE ##1 state_q == pulse_origin_pkg::S_DONE);
  limit_fault_c: cover property (seeking && blocked);
  cw_pulse_c: cover property ($rose(cw_pulse_line));

endmodule : pulse_origin_io

// ---- drive_model.sv ----
/*
  Behavioural stepping or servo drive: counts pulses into a shaft position and
  answers with proximity, origin and positioning done lines.
  Assumes pulse lines are registered on aclk and high while the transistor is on.
*/
`timescale 1ns/1ps
module drive_model (
  input wire logic aclk,        // system clock
  input wire logic aresetn,     // synchronous reset, active low
  input wire logic step_mode,   // 1 = step plus direction wiring
  input wire logic step_in,     // step pulses
  input wire logic cw_in,       // clockwise pulses
  input wire logic ccw_dir_in,  // ccw pulses or direction level
  input wire logic hold_done,   // keeps positioning done off on command
  output logic origin_out,      // origin mark once every 8 steps
  output logic prox_out,        // proximity level
  output logic done_out,        // positioning completed
  output int cw_cnt,            // clockwise pulses seen
  output int ccw_cnt,           // counter-clockwise pulses seen
  output int step_cnt           // step pulses seen
);
  localparam int SETTLE = 16;
  logic step_q;
  logic cw_q;
  logic ccw_q;
  int pos;
  int quiet;

  // count pulse rises and move the shaft
  always_ff @(posedge aclk) begin
    step_q <= step_in;
    cw_q <= cw_in;
    ccw_q <= ccw_dir_in;
    if (!aresetn) begin
      pos <= 0;
      quiet <= 0;
      cw_cnt <= 0;
      ccw_cnt <= 0;
      step_cnt <= 0;
    end else if (step_mode && step_in && !step_q) begin
      step_cnt <= step_cnt + 1;
      pos <= ccw_dir_in ? pos + 1 : pos - 1;
      quiet <= 0;
    end else if (!step_mode && cw_in && !cw_q) begin
      cw_cnt <= cw_cnt + 1;
      pos <= pos + 1;
      quiet <= 0;
    end else if (!step_mode && ccw_dir_in && !ccw_q) begin
      ccw_cnt <= ccw_cnt + 1;
      pos <= pos - 1;
      quiet <= 0;
    end else if (quiet < 1000) begin
      quiet <= quiet + 1;
    end
  end

  // done off while moving, on once stopped for a while
  assign done_out = !hold_done && (quiet >= SETTLE);
  assign prox_out = (pos >= 4);
  assign origin_out = ((pos & 7) == 6);
endmodule : drive_model

// ---- testbench.sv ----
/*
  Self-checking bench for the pulse output and origin search channel.
  Assumes the drive model beside it and a 250 MHz clock.
*/
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} exp_t;
  logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic awready, wready, arready, step, cw, ccw_dir, ec, org, prox, pdone, step_mode, hold_done, ce;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, got;
  logic [1:0] bresp, rresp;
  int cw_cnt, ccw_cnt, step_cnt, miscompares, num_checks, ec_run, ec_last, ec_pulses, dcw, dccw, dstep, e0;
  logic dirl;
  exp_t rq[$];
  logic [1:0] wq[$];

  pulse_origin_io DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .origin_in_line(org),
    .origin_proximity_line(prox), .positioning_done_line(pdone), .step_pulse_line(step),
    .cw_pulse_line(cw), .ccw_or_direction_line(ccw_dir), .error_clear_line(ec));
  drive_model drive (.aclk(aclk), .aresetn(aresetn), .step_mode(step_mode), .step_in(step), .cw_in(cw),
    .ccw_dir_in(ccw_dir), .hold_done(hold_done), .origin_out(org), .prox_out(prox), .done_out(pdone),
    .cw_cnt(cw_cnt), .ccw_cnt(ccw_cnt), .step_cnt(step_cnt));

  // clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic wait_lost;
    miscompares++;
    $display("[ERR] %0t wait ran out", $time);
    final_report();
  endtask : wait_lost

  // one write; handshakes judged at the falling edge before the taking edge
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    wq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hs = 1'b0;
    for (int i = 0; i < 50 && !b_hs; i++) begin
      @(negedge aclk);
      aw_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid && bready;
      @(posedge aclk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
    if (!b_hs) wait_lost();
  endtask : axi_wr

  // one read; expectation noted with a mask of bits that matter
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    logic ar_hs, r_hs;
    rq.push_back('{d, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hs = 1'b0;
    for (int i = 0; i < 50 && !r_hs; i++) begin
      @(negedge aclk);
      ar_hs = arvalid && arready;
      r_hs = rvalid && rready;
      got = rdata;
      @(posedge aclk);
      if (ar_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
    if (!r_hs) wait_lost();
  endtask : axi_rd

  // poll status until one of the wanted bits shows
  task automatic poll(input logic [31:0] want);
    got = 32'h0;
    for (int i = 0; i < 1500 && (got & want) == 32'h0; i++)
      axi_rd(pulse_origin_pkg::ADDR_STATUS, 32'h0, 32'h0, pulse_origin_pkg::RESP_OKAY);
    if ((got & want) == 32'h0) wait_lost();
  endtask : poll

  // run pulses with control byte c, stop, then watch the idle lines
  task automatic burst(input logic [7:0] c);
    int a, b, s, f;
    logic idle;
    a = cw_cnt;
    b = ccw_cnt;
    s = step_cnt;
    idle = 1'b0;
    step_mode <= c[0];
    axi_wr(pulse_origin_pkg::ADDR_CTRL, {24'h0, c}, 4'h1, pulse_origin_pkg::RESP_OKAY);
    repeat (40) @(posedge aclk);
    @(negedge aclk);
    dirl = ccw_dir;
    @(posedge aclk);
    // freeze mid-run: lines must stand still and the bus must refuse everything
    ce <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    f = cw_cnt + ccw_cnt + step_cnt;
    repeat (8) @(negedge aclk);
    check(32'(cw_cnt + ccw_cnt + step_cnt - f), 32'h0);
    check(32'({awready, wready, arready}), 32'h0);
    @(posedge aclk);
    ce <= 1'b1;
    axi_wr(pulse_origin_pkg::ADDR_CTRL, {24'h0, c & 8'hc1}, 4'h1, pulse_origin_pkg::RESP_OKAY);
    repeat (4) @(posedge aclk);
    repeat (20) begin
      @(negedge aclk);
      idle = idle | step | cw | (ccw_dir & !c[0]);
    end
    @(posedge aclk);
    check(32'(idle), 32'h0);
    dcw = cw_cnt - a;
    dccw = ccw_cnt - b;
    dstep = step_cnt - s;
  endtask : burst

  // compare every answer with the oldest note
  always @(negedge aclk) begin
    if (bvalid && bready && wq.size() != 0)
      check(32'(bresp), 32'(wq.pop_front()));
    if (rvalid && rready && rq.size() != 0) begin
      check(rdata & rq[0].m, rq[0].d & rq[0].m);
      check(32'(rresp), 32'(rq[0].r));
      void'(rq.pop_front());
    end
  end

  // measure each error clear pulse
  always @(negedge aclk) begin
    if (ec === 1'b1) begin
      ec_run <= ec_run + 1;
    end else if (ec_run != 0) begin
      ec_last <= ec_run;
      ec_run <= 0;
      ec_pulses <= ec_pulses + 1;
    end
  end

  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, step_mode, hold_done} = 8'h00;
    ce = 1'b1;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    {miscompares, num_checks, ec_run, ec_last, ec_pulses} = 160'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    void'($urandom(32'h367b));
    axi_rd(pulse_origin_pkg::ADDR_CTRL, 32'h0, '1, pulse_origin_pkg::RESP_OKAY);
    axi_rd(pulse_origin_pkg::ADDR_PERIOD, 32'h64, '1, pulse_origin_pkg::RESP_OKAY);
    axi_rd(pulse_origin_pkg::ADDR_STATUS, 32'h0, '1, pulse_origin_pkg::RESP_OKAY);
    axi_rd(4'h2, 32'h0, '1, pulse_origin_pkg::RESP_SLVERR);
    axi_wr(4'h2, 32'h1, 4'hf, pulse_origin_pkg::RESP_SLVERR);
    axi_wr(pulse_origin_pkg::ADDR_STATUS, 32'h1, 4'hf, pulse_origin_pkg::RESP_OKAY);
    axi_wr(pulse_origin_pkg::ADDR_PERIOD, $urandom_range(3, 1), 4'h3, pulse_origin_pkg::RESP_OKAY);
    burst(8'h18);
    check(32'(dcw != 0), 32'h1);
    check(32'(dccw + dstep), 32'h0);
    burst(8'h08);
    check(32'(dccw != 0), 32'h1);
    check(32'(dcw + dstep), 32'h0);
    burst(8'h19);
    check(32'(dstep != 0), 32'h1);
    check(32'(dirl), 32'h1);
    burst(8'h09);
    check(32'(dstep != 0), 32'h1);
    check(32'(dirl), 32'h0);
    burst(8'h58);
    check(32'(dcw), 32'h0);
    // mode 3 is expected to act as mode 1
    for (int m = 0; m < 4; m++) begin
      hold_done <= (m != 1);
      e0 = ec_pulses;
      axi_wr(pulse_origin_pkg::ADDR_CTRL, 32'h120 | (m << 1), 4'h3, pulse_origin_pkg::RESP_OKAY);
      poll((m == 2) ? 32'h08 : 32'h10);
      if (m == 2) begin
        repeat (100) @(posedge aclk);
        axi_rd(pulse_origin_pkg::ADDR_STATUS, 32'h08, 32'h18, pulse_origin_pkg::RESP_OKAY);
        hold_done <= 1'b0;
        poll(32'h10);
      end
      check(32'(got[4]), 32'h1);
      axi_rd(pulse_origin_pkg::ADDR_POS, 32'h0, '1, pulse_origin_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      check(32'(ec_pulses - e0), 32'(m != 0));
      if (m != 0)
        check(32'(ec_last), 32'(pulse_origin_pkg::ERR_CLEAR_CYC));
    end
    // search straight into a set limit: fault, no pulses
    e0 = cw_cnt;
    axi_wr(pulse_origin_pkg::ADDR_CTRL, 32'h160, 4'h3, pulse_origin_pkg::RESP_OKAY);
    poll(32'h20);
    check(32'(got[5]), 32'h1);
    check(32'(cw_cnt - e0), 32'h0);
    final_report();
  end
endmodule : testbench
